// *** core/ext_alu_pkg.sv ***
// package for the table-read and extended alu datapath
// assumes one core clock; decoder supplies one decoded operation at a time
package ext_alu_pkg;

   localparam int DMEM_ADDR_W = 16;
   localparam int PROG_ADDR_W = 16;
   localparam int PROG_DATA_W = 16;
   localparam int REG_ADDR_W  = 3;

   // software register offsets
   localparam logic [2:0] OFS_WORK   = 3'h0;
   localparam logic [2:0] OFS_FLAGS  = 3'h1;
   localparam logic [2:0] OFS_TPL    = 3'h2;
   localparam logic [2:0] OFS_TPH    = 3'h3;
   localparam logic [2:0] OFS_LATCH  = 3'h4;
   localparam logic [2:0] OFS_STATUS = 3'h5;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   // decimal adjust constants
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [7:0] BCD_ADJ_LOW   = 8'h06;
   localparam logic [7:0] BCD_ADJ_HIGH  = 8'h60;

   // flag bit positions in the flags register
   localparam int FLAG_POS_CARRY  = 0;
   localparam int FLAG_POS_HALF   = 1;
   localparam int FLAG_POS_ZERO   = 2;
   localparam int FLAG_POS_WRAP   = 3;
   localparam int FLAG_POS_SIGNED = 4;

   typedef enum logic [4:0] {
      OP_TABLE_READ_PAGED,
      OP_TABLE_READ_LAST_PAGE,
      OP_TABLE_READ_PREINC_PAGED,
      OP_TABLE_READ_PREINC_LAST,
      OP_XOR_MEMORY,
      OP_XOR_IMMEDIATE,
      OP_ADD,
      OP_ADD_CARRY,
      OP_AND,
      OP_OR,
      OP_CLEAR,
      OP_CLEAR_BIT,
      OP_INVERT,
      OP_DECIMAL_ADJUST,
      OP_DECREMENT,
      OP_INCREMENT,
      OP_MOVE_TO_WORK,
      OP_MOVE_TO_MEMORY,
      OP_ROTATE_LEFT,
      OP_ROTATE_LEFT_CARRY
   } opcode_e;

   typedef struct packed {
      opcode_e                 code;
      logic [DMEM_ADDR_W-1:0]  addr;
      logic [2:0]              bit_sel;
      logic [7:0]              immediate;
      logic                    to_work;
   } op_s;

   typedef struct packed {
      logic signed_carry_flag;
      logic signed_wrap_flag;
      logic zero;
      logic half_carry;
      logic carry;
   } flags_s;

endpackage

// *** core/ext_alu_datapath.sv ***
// execution datapath: table reads, exclusive-or, extended memory operations
// assumes program and data memory answer a read strobe one cycle later;
// decoder, memories and register port all run on SYS_CLK_IN
//
// Behaviour
// - paged table read: word at both pointer bytes, low to memory, high to latch
// - last-page table read: pointer low byte within last page, same stores
// - pre-increment pointer low byte, then paged table read
// - pre-increment pointer low byte, then last-page table read
// - exclusive-or with memory (result to work or memory) or immediate (result to work), zero only
// - extended operations take a full data address reaching every section
// - add with carry updates wrap, zero, half-carry, carry, signed carry
// - add without carry updates same five flags
// - bitwise and, zero flag only
// - bitwise or, zero flag only
// - clear byte or single bit, no flag change
// - invert operand to memory or work, zero flag updated
// - decimal adjust adds six per nibble over nine or carried, store memory
// - decimal adjust changes carry only, set when sum passed one hundred
// - decrement to memory or work, zero flag only
// - increment to memory or work, zero flag only
// - move between memory and work, no flags
// - rotate left, bit seven into bit zero, no flags
// - rotate left through carry, only carry changes
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps

module ext_alu_datapath #(
   parameter int DMEM_AW = ext_alu_pkg::DMEM_ADDR_W,
   parameter int PROG_AW = ext_alu_pkg::PROG_ADDR_W,
   parameter int PROG_DW = ext_alu_pkg::PROG_DATA_W
) (
   input  wire logic                                SYS_CLK_IN,
   input  wire logic                                RST_N_IN,
   input  wire logic                                CE_IN,
   input  wire logic                                OP_VALID_IN,
   input  wire ext_alu_pkg::op_s                    OP_IN,
   output logic                                     OP_READY_OUT,
   output logic                                     OP_DONE_OUT,
   output logic [PROG_AW-1:0]                       PROG_ADDR_OUT,
   output logic                                     PROG_RD_OUT,
   input  wire logic [PROG_DW-1:0]                  PROG_DATA_IN,
   output logic [DMEM_AW-1:0]                       DMEM_ADDR_OUT,
   output logic                                     DMEM_RD_OUT,
   input  wire logic [7:0]                          DMEM_RDATA_IN,
   output logic                                     DMEM_WR_OUT,
   output logic [7:0]                               DMEM_WDATA_OUT,
   input  wire logic [ext_alu_pkg::REG_ADDR_W-1:0]  REG_ADDR_IN,
   input  wire logic [7:0]                          REG_WDATA_IN,
   input  wire logic                                REG_WR_IN,
   input  wire logic                                REG_RD_IN,
   output logic [7:0]                               REG_RDATA_OUT,
   output logic [7:0]                               WORK_OUT,
   output ext_alu_pkg::flags_s                      FLAGS_OUT,
   output logic [7:0]                               TABLE_HIGH_OUT
);

   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_EXEC} state_e;

   state_e              state;
   ext_alu_pkg::op_s    op;
   ext_alu_pkg::flags_s flags;
   logic [7:0]          working_register;
   logic [7:0]          table_pointer_low;
   logic [7:0]          table_pointer_high;
   logic [7:0]          table_read_high_latch;

   logic                accept;
   logic                is_table;
   logic                is_preinc;
   logic                is_last_page;
   logic [7:0]          next_pointer_low;
   logic [PROG_AW-1:0]  next_prog_addr;

   logic [7:0]          operand;
   logic [7:0]          result;
   ext_alu_pkg::flags_s next_flags;
   logic                write_work;
   logic                write_mem;
   logic [8:0]          sum;
   logic [4:0]          low_sum;
   logic                carry_into_top;
   logic                adj_low;
   logic                adj_high;

   assign OP_READY_OUT   = (state == ST_IDLE);
   assign accept         = CE_IN && OP_VALID_IN && (state == ST_IDLE);
   assign WORK_OUT       = working_register;
   assign FLAGS_OUT      = flags;
   assign TABLE_HIGH_OUT = table_read_high_latch;

   ////////////////////////////////////////////////////////////////////////////////
   // address generation for table reads

   always_comb begin
      is_table     = (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_PAGED)
                  || (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_LAST_PAGE)
                  || (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_PREINC_PAGED)
                  || (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_PREINC_LAST);
      is_preinc    = (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_PREINC_PAGED)
                  || (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_PREINC_LAST);
      is_last_page = (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_LAST_PAGE)
                  || (OP_IN.code == ext_alu_pkg::OP_TABLE_READ_PREINC_LAST);
      next_pointer_low = is_preinc ? 8'(table_pointer_low + 8'h01) : table_pointer_low;
      if (is_last_page) begin
         // last page select
         // upper address bits all ones pick the final page of program memory
         next_prog_addr = {{(PROG_AW-8){1'b1}}, next_pointer_low};
      end else begin
         next_prog_addr = PROG_AW'({table_pointer_high, next_pointer_low});
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing: accept, issue read, execute

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         state <= ST_IDLE;
         op    <= '0;
      end else if (CE_IN) begin
         case (state)
            ST_IDLE: begin
               if (OP_VALID_IN) begin
                  op    <= OP_IN;
                  state <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               state <= ST_EXEC;
            end
            ST_EXEC: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // read strobes stand in ST_ISSUE; data arrives in ST_EXEC
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         PROG_RD_OUT   <= 1'b0;
         PROG_ADDR_OUT <= '0;
         DMEM_RD_OUT   <= 1'b0;
         DMEM_ADDR_OUT <= '0;
      end else if (CE_IN) begin
         PROG_RD_OUT <= accept && is_table;
         DMEM_RD_OUT <= accept && !is_table;
         if (accept) begin
            PROG_ADDR_OUT <= next_prog_addr;
            DMEM_ADDR_OUT <= DMEM_AW'(OP_IN.addr);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // arithmetic and logic

   always_comb begin
      operand        = (op.code == ext_alu_pkg::OP_XOR_IMMEDIATE) ? op.immediate
                                                                  : DMEM_RDATA_IN;
      result         = operand;
      next_flags     = flags;
      write_work     = 1'b0;
      write_mem      = 1'b0;
      sum            = '0;
      low_sum        = '0;
      carry_into_top = 1'b0;
      adj_low        = 1'b0;
      adj_high       = 1'b0;
      case (op.code)
         ext_alu_pkg::OP_XOR_MEMORY, ext_alu_pkg::OP_XOR_IMMEDIATE: begin
            result          = working_register ^ operand;
            next_flags.zero = (result == 8'h00);
            write_work      = op.to_work || (op.code == ext_alu_pkg::OP_XOR_IMMEDIATE);
            write_mem       = !write_work;
         end
         ext_alu_pkg::OP_ADD, ext_alu_pkg::OP_ADD_CARRY: begin
            carry_into_top = (op.code == ext_alu_pkg::OP_ADD_CARRY) && flags.carry;
            low_sum = {1'b0, working_register[3:0]} + {1'b0, operand[3:0]}
                    + {4'h0, carry_into_top};
            sum     = {1'b0, working_register} + {1'b0, operand} + {8'h00, carry_into_top};
            result  = sum[7:0];
            next_flags.carry             = sum[8];
            next_flags.half_carry        = low_sum[4];
            next_flags.zero              = (result == 8'h00);
            // wrap when both operands share a sign that the result lacks
            next_flags.signed_wrap_flag  = (working_register[7] == operand[7])
                                        && (result[7] != operand[7]);
            next_flags.signed_carry_flag = next_flags.signed_wrap_flag ^ result[7];
            write_work = op.to_work;
            write_mem  = !op.to_work;
         end
         ext_alu_pkg::OP_AND: begin
            result          = working_register & operand;
            next_flags.zero = (result == 8'h00);
            write_work      = op.to_work;
            write_mem       = !op.to_work;
         end
         ext_alu_pkg::OP_OR: begin
            result          = working_register | operand;
            next_flags.zero = (result == 8'h00);
            write_work      = op.to_work;
            write_mem       = !op.to_work;
         end
         ext_alu_pkg::OP_CLEAR: begin
            result    = ext_alu_pkg::RST_BYTE;
            write_mem = 1'b1;
         end
         ext_alu_pkg::OP_CLEAR_BIT: begin
            result              = operand;
            result[op.bit_sel]  = 1'b0;
            write_mem           = 1'b1;
         end
         ext_alu_pkg::OP_INVERT: begin
            result          = ~operand;
            next_flags.zero = (result == 8'h00);
            write_work      = op.to_work;
            write_mem       = !op.to_work;
         end
         ext_alu_pkg::OP_DECIMAL_ADJUST: begin
            adj_low  = (working_register[3:0] > ext_alu_pkg::BCD_MAX_DIGIT) || flags.half_carry;
            adj_high = (working_register[7:4] > ext_alu_pkg::BCD_MAX_DIGIT) || flags.carry;
            sum      = {1'b0, working_register}
                     + {1'b0, (adj_low  ? ext_alu_pkg::BCD_ADJ_LOW  : 8'h00)}
                     + {1'b0, (adj_high ? ext_alu_pkg::BCD_ADJ_HIGH : 8'h00)};
            result   = sum[7:0];
            next_flags.carry = flags.carry || adj_high || sum[8];
            write_mem        = 1'b1;
         end
         ext_alu_pkg::OP_DECREMENT: begin
            result          = 8'(operand - 8'h01);
            next_flags.zero = (result == 8'h00);
            write_work      = op.to_work;
            write_mem       = !op.to_work;
         end
         ext_alu_pkg::OP_INCREMENT: begin
            result          = 8'(operand + 8'h01);
            next_flags.zero = (result == 8'h00);
            write_work      = op.to_work;
            write_mem       = !op.to_work;
         end
         ext_alu_pkg::OP_MOVE_TO_WORK: begin
            result     = operand;
            write_work = 1'b1;
         end
         ext_alu_pkg::OP_MOVE_TO_MEMORY: begin
            result    = working_register;
            write_mem = 1'b1;
         end
         ext_alu_pkg::OP_ROTATE_LEFT: begin
            result     = {operand[6:0], operand[7]};
            write_work = op.to_work;
            write_mem  = !op.to_work;
         end
         ext_alu_pkg::OP_ROTATE_LEFT_CARRY: begin
            result           = {operand[6:0], flags.carry};
            next_flags.carry = operand[7];
            write_work       = op.to_work;
            write_mem        = !op.to_work;
         end
         default: begin
            // table reads: low byte of the program word goes to data memory
            result    = PROG_DATA_IN[7:0];
            write_mem = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state registers; the datapath wins over a software write in the same cycle

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         working_register <= ext_alu_pkg::RST_BYTE;
      end else if (CE_IN) begin
         if (state == ST_EXEC && write_work) begin
            working_register <= result;
         end else if (REG_WR_IN && REG_ADDR_IN == ext_alu_pkg::OFS_WORK) begin
            working_register <= REG_WDATA_IN;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         flags <= '0;
      end else if (CE_IN) begin
         if (state == ST_EXEC) begin
            flags <= next_flags;
         end else if (REG_WR_IN && REG_ADDR_IN == ext_alu_pkg::OFS_FLAGS) begin
            flags <= REG_WDATA_IN[4:0];
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         table_pointer_low <= ext_alu_pkg::RST_BYTE;
      end else if (CE_IN) begin
         if (accept && is_preinc) begin
            table_pointer_low <= next_pointer_low;
         end else if (REG_WR_IN && REG_ADDR_IN == ext_alu_pkg::OFS_TPL) begin
            table_pointer_low <= REG_WDATA_IN;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         table_pointer_high <= ext_alu_pkg::RST_BYTE;
      end else if (CE_IN && REG_WR_IN && REG_ADDR_IN == ext_alu_pkg::OFS_TPH) begin
         table_pointer_high <= REG_WDATA_IN;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         table_read_high_latch <= ext_alu_pkg::RST_BYTE;
      end else if (CE_IN && state == ST_EXEC && PROG_RD_OUT == 1'b0
                   && op.code inside {ext_alu_pkg::OP_TABLE_READ_PAGED,
                                      ext_alu_pkg::OP_TABLE_READ_LAST_PAGE,
                                      ext_alu_pkg::OP_TABLE_READ_PREINC_PAGED,
                                      ext_alu_pkg::OP_TABLE_READ_PREINC_LAST}) begin
         table_read_high_latch <= 8'(PROG_DATA_IN[PROG_DW-1:8]);
      end
   end

   // memory write and completion, one cycle after ST_EXEC
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         DMEM_WR_OUT    <= 1'b0;
         DMEM_WDATA_OUT <= ext_alu_pkg::RST_BYTE;
         OP_DONE_OUT    <= 1'b0;
      end else if (CE_IN) begin
         DMEM_WR_OUT <= (state == ST_EXEC) && write_mem;
         OP_DONE_OUT <= (state == ST_EXEC);
         if (state == ST_EXEC) begin
            DMEM_WDATA_OUT <= result;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software read port

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_N_IN) begin
         REG_RDATA_OUT <= ext_alu_pkg::RST_BYTE;
      end else if (CE_IN) begin
         if (!REG_RD_IN) begin
            REG_RDATA_OUT <= 8'h00;
         end else if (REG_ADDR_IN == ext_alu_pkg::OFS_WORK) begin
            REG_RDATA_OUT <= working_register;
         end else if (REG_ADDR_IN == ext_alu_pkg::OFS_FLAGS) begin
            REG_RDATA_OUT <= {3'h0, flags};
         end else if (REG_ADDR_IN == ext_alu_pkg::OFS_TPL) begin
            REG_RDATA_OUT <= table_pointer_low;
         end else if (REG_ADDR_IN == ext_alu_pkg::OFS_TPH) begin
            REG_RDATA_OUT <= table_pointer_high;
         end else if (REG_ADDR_IN == ext_alu_pkg::OFS_LATCH) begin
            REG_RDATA_OUT <= table_read_high_latch;
         end else if (REG_ADDR_IN == ext_alu_pkg::OFS_STATUS) begin
            REG_RDATA_OUT <= {7'h00, (state != ST_IDLE)};
         end else begin
            REG_RDATA_OUT <= 8'h00;
         end
      end
   end

endmodule

// *** test/mem_model.sv ***
// program and data memory model across the datapath's memory ports
// assumes one clock; read data is valid only in the cycle after a strobe
`timescale 1ns/1ps
module mem_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] prog_addr_in,
   input  wire logic        prog_rd_in,
   output logic [15:0]      prog_data_out,
   input  wire logic [15:0] dmem_addr_in,
   input  wire logic        dmem_rd_in,
   input  wire logic        dmem_wr_in,
   input  wire logic [7:0]  dmem_wdata_in,
   output logic [7:0]       dmem_rdata_out
);
   logic [7:0] dmem [logic [15:0]];
   ////////////////////////////////////////
   // program word follows its address so the bench can predict every fetch;
   // outside a read both buses flip each cycle, so stale data never matches
   initial begin
      prog_data_out = 16'h0000;
      dmem_rdata_out = 8'h00;
      forever begin
         @(posedge clk_in);
         prog_data_out <= prog_rd_in ? {prog_addr_in[7:0] ^ 8'h5A,
            prog_addr_in[7:0] + prog_addr_in[15:8]} : ~prog_data_out;
         if (!dmem_rd_in)
            dmem_rdata_out <= ~dmem_rdata_out;
         else if (dmem.exists(dmem_addr_in))
            dmem_rdata_out <= dmem[dmem_addr_in];
         else
            dmem_rdata_out <= 8'h00;
         if (dmem_wr_in)
            dmem[dmem_addr_in] = dmem_wdata_in;
      end
   end
endmodule

// *** test/ext_alu_checker.sv ***
// port-level checks bound into every datapath instance
// assumes CE_IN stays high while an operation runs
`timescale 1ns/1ps
module ext_alu_checker #(
   parameter int DMEM_AW = 16,
   parameter int PROG_AW = 16,
   parameter int PROG_DW = 16
) (
   input  wire logic                SYS_CLK_IN,
   input  wire logic                RST_N_IN,
   input  wire logic                CE_IN,
   input  wire logic                OP_VALID_IN,
   input  wire ext_alu_pkg::op_s    OP_IN,
   input  wire logic                OP_READY_OUT,
   input  wire logic                OP_DONE_OUT,
   input  wire logic [PROG_AW-1:0]  PROG_ADDR_OUT,
   input  wire logic                PROG_RD_OUT,
   input  wire logic [PROG_DW-1:0]  PROG_DATA_IN,
   input  wire logic [DMEM_AW-1:0]  DMEM_ADDR_OUT,
   input  wire logic                DMEM_RD_OUT,
   input  wire logic                DMEM_WR_OUT,
   input  wire logic [7:0]          DMEM_WDATA_OUT,
   input  wire logic [7:0]          WORK_OUT,
   input  wire ext_alu_pkg::flags_s FLAGS_OUT,
   input  wire logic [7:0]          TABLE_HIGH_OUT
);
   logic               take, tbl, last, zop, steady, conly;
   logic [DMEM_AW-1:0] op_addr;
   logic [7:0]         word_lo, word_hi;
   logic [3:0]         not_zero, not_carry;
   assign take = CE_IN && OP_VALID_IN && OP_READY_OUT;
   // groups by encoding, so a reordered enum shows up here first
   assign tbl = take && OP_IN.code inside {[5'h00:5'h03]};
   assign last = take && OP_IN.code inside {5'h01, 5'h03};
   assign zop = take && OP_IN.code inside {5'h04, 5'h05, 5'h08, 5'h09, 5'h0C, 5'h0E, 5'h0F};
   assign steady = tbl || (take && OP_IN.code inside {5'h0A, 5'h0B, 5'h10, 5'h11, 5'h12});
   assign conly = take && OP_IN.code inside {5'h0D, 5'h13};
   assign op_addr = OP_IN.addr;
   assign word_lo = PROG_DATA_IN[7:0];
   assign word_hi = PROG_DATA_IN[15:8];
   assign not_zero = {FLAGS_OUT.signed_carry_flag, FLAGS_OUT.signed_wrap_flag,
                      FLAGS_OUT.half_carry, FLAGS_OUT.carry};
   assign not_carry = {FLAGS_OUT.signed_carry_flag, FLAGS_OUT.signed_wrap_flag,
                       FLAGS_OUT.zero, FLAGS_OUT.half_carry};
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence s_busy;
      !OP_READY_OUT [*2];
   endsequence
   sequence s_finish;
      OP_READY_OUT && OP_DONE_OUT;
   endsequence
   ////////////////////////////////////////
   a_done_exact: assert property (take |=> s_busy ##1 s_finish)
      else $error("done not three cycles after take");
   a_done_cause: assert property (OP_DONE_OUT |-> $past(take, 3))
      else $error("done without an operation");
   a_tbl_fetch: assert property (tbl |=> PROG_RD_OUT && !DMEM_RD_OUT)
      else $error("table read did not fetch program memory");
   a_last_page: assert property (last |=> PROG_ADDR_OUT[PROG_AW-1:8] == '1)
      else $error("last page address wrong");
   a_tbl_split: assert property (tbl |-> ##3 DMEM_WR_OUT &&
      DMEM_WDATA_OUT == $past(word_lo) && TABLE_HIGH_OUT == $past(word_hi))
      else $error("table word split wrong");
   a_full_addr: assert property (take |-> ##3 !DMEM_WR_OUT ||
      DMEM_ADDR_OUT == $past(op_addr, 3))
      else $error("write address differs from operand address");
   a_flags_hold: assert property (steady |=> $stable(FLAGS_OUT) [*3])
      else $error("flags changed on a flag-free operation");
   a_zero_track: assert property (zop |-> ##3 FLAGS_OUT.zero ==
      (DMEM_WR_OUT ? DMEM_WDATA_OUT == 8'h00 : WORK_OUT == 8'h00))
      else $error("zero flag does not match result");
   a_zero_only: assert property (zop |=> $stable(not_zero) [*3])
      else $error("flag other than zero changed");
   a_carry_only: assert property (conly |=> $stable(not_carry) [*3])
      else $error("flag other than carry changed");
endmodule

bind ext_alu_datapath ext_alu_checker #(
   .DMEM_AW(DMEM_AW), .PROG_AW(PROG_AW), .PROG_DW(PROG_DW)
) ext_alu_checker_inst (
   .SYS_CLK_IN, .RST_N_IN, .CE_IN, .OP_VALID_IN, .OP_IN, .OP_READY_OUT,
   .OP_DONE_OUT, .PROG_ADDR_OUT, .PROG_RD_OUT, .PROG_DATA_IN, .DMEM_ADDR_OUT,
   .DMEM_RD_OUT, .DMEM_WR_OUT, .DMEM_WDATA_OUT, .WORK_OUT, .FLAGS_OUT, .TABLE_HIGH_OUT
);

// *** test/tb_top.sv ***
// self-checking bench for the table-read and extended datapath
// assumes the memory model answers every read strobe in the next cycle
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [7:0] c, w, i, a, m, f, x, r;
   } vec_s;
   // opcode, to work, immediate or bit, work, memory, flags in, flags out, result
   localparam logic [63:0] VECS [22] = '{
      64'h06_01_00_7F_01_00_0A_80, 64'h07_00_00_FF_00_01_07_00,
      64'h08_01_00_F0_0F_1B_1F_00, 64'h09_00_00_50_0A_1F_1B_5A,
      64'h04_00_00_AA_AA_00_04_00, 64'h05_01_0F_3C_00_04_00_33,
      64'h0A_00_00_11_FF_1B_1B_00, 64'h0B_00_07_11_FF_04_04_7F,
      64'h0C_01_00_11_FF_00_04_00, 64'h0C_00_00_11_0F_04_00_F0,
      64'h0D_00_00_A5_00_1A_1B_0B, 64'h0D_00_00_12_00_04_04_12,
      64'h0E_00_00_11_01_01_05_00, 64'h0E_01_00_11_00_05_01_FF,
      64'h0F_01_00_11_FF_00_04_00, 64'h0F_00_00_11_7F_04_00_80,
      64'h10_01_00_11_C3_1F_1F_C3, 64'h11_00_00_3C_55_00_00_3C,
      64'h12_00_00_11_81_00_00_03, 64'h12_01_00_11_40_01_01_80,
      64'h13_00_00_11_80_00_01_00, 64'h13_01_00_11_01_05_04_03};
   logic                clk, rst_n, valid, ready, done, prd, drd, dwr, rwr, rrd;
   ext_alu_pkg::op_s    op;
   ext_alu_pkg::flags_s flags;
   logic [15:0]         paddr, pdata, daddr;
   logic [7:0]          drdata, dwdata, rwdata, rrdata, work, latch;
   logic [2:0]          raddr;
   int                  n_fail, check_count;

   ext_alu_datapath ext_alu_datapath_inst (
      .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .OP_VALID_IN(valid),
      .OP_IN(op), .OP_READY_OUT(ready), .OP_DONE_OUT(done), .PROG_ADDR_OUT(paddr),
      .PROG_RD_OUT(prd), .PROG_DATA_IN(pdata), .DMEM_ADDR_OUT(daddr),
      .DMEM_RD_OUT(drd), .DMEM_RDATA_IN(drdata), .DMEM_WR_OUT(dwr),
      .DMEM_WDATA_OUT(dwdata), .REG_ADDR_IN(raddr), .REG_WDATA_IN(rwdata),
      .REG_WR_IN(rwr), .REG_RD_IN(rrd), .REG_RDATA_OUT(rrdata), .WORK_OUT(work),
      .FLAGS_OUT(flags), .TABLE_HIGH_OUT(latch));
   mem_model mem_model_inst (
      .clk_in(clk), .prog_addr_in(paddr), .prog_rd_in(prd), .prog_data_out(pdata),
      .dmem_addr_in(daddr), .dmem_rd_in(drd), .dmem_wr_in(dwr),
      .dmem_wdata_in(dwdata), .dmem_rdata_out(drdata));
   ////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      raddr <= a;
      rwdata <= d;
      rwr <= 1'b1;
      @(posedge clk);
      rwr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      raddr <= a;
      rrd <= 1'b1;
      @(posedge clk);
      rrd <= 1'b0;
      @(posedge clk);
      d = rrdata;
   endtask
   // valid stays up while busy, so the two refused offers must not start a second op
   task automatic run_op(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] i,
                         input logic w);
      logic got;
      @(posedge clk);
      valid <= 1'b1;
      op <= '{ext_alu_pkg::opcode_e'(c[4:0]), ad, i[2:0], i, w};
      repeat (3) @(posedge clk);
      valid <= 1'b0;
      got = 1'b0;
      for (int n = 0; n < 4 && !got; n++) begin
         @(posedge clk);
         got = (done === 1'b1);
      end
      check("op done", {7'h00, got}, 8'h01);
      if (!got) conclude();
      #1;
   endtask
   ////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] d;
      reg_wr(ext_alu_pkg::OFS_LATCH, 8'hFF);
      for (int a = 0; a < 8; a++) begin
         reg_rd(3'(a), d);
         check("reset register", d, 8'h00);
      end
      $display("register test finished");
   endtask
   // pointer low starts at FF so the pre-increment wraps to 00
   task automatic t_table();
      logic [7:0]  p, d;
      logic [15:0] pa, ad;
      for (int k = 0; k < 4; k++) begin
         ad = 16'hC300 + 16'(k);
         reg_wr(ext_alu_pkg::OFS_TPL, 8'hFF);
         reg_wr(ext_alu_pkg::OFS_TPH, 8'h12);
         reg_wr(ext_alu_pkg::OFS_FLAGS, 8'h15);
         run_op(8'(k), ad, 8'h00, 1'b0);
         p = (k > 1) ? 8'h00 : 8'hFF;
         pa = {(k % 2 == 1) ? 8'hFF : 8'h12, p};
         check("table low", mem_model_inst.dmem[ad], p + pa[15:8]);
         check("table high", latch, p ^ 8'h5A);
         check("table flags", 8'(flags), 8'h15);
         reg_rd(ext_alu_pkg::OFS_TPL, d);
         check("pointer low", d, p);
      end
      $display("table test finished");
   endtask
   // each vector sits in its own memory section
   task automatic t_alu();
      vec_s        v;
      logic [15:0] ad;
      for (int k = 0; k < 22; k++) begin
         v = VECS[k];
         ad = {8'(k), 8'(k)};
         mem_model_inst.dmem[ad] = v.m;
         reg_wr(ext_alu_pkg::OFS_WORK, v.a);
         reg_wr(ext_alu_pkg::OFS_FLAGS, v.f);
         run_op(v.c, ad, v.i, v.w[0]);
         check("work", work, v.w[0] ? v.r : v.a);
         check("memory", mem_model_inst.dmem[ad], v.w[0] ? v.m : v.r);
         check("flags", 8'(flags), v.x);
      end
      $display("arithmetic test finished");
   endtask
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      valid = 1'b0;
      op = '0;
      raddr = 3'h0;
      rwdata = 8'h00;
      rwr = 1'b0;
      rrd = 1'b0;
      n_fail = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_table();
      t_alu();
      conclude();
   end
endmodule
